// ===== src/pcs_pkg.sv
// Purpose: shared constants and types of the programmable crc sequencer
// Assumes: 32-bit ahb-lite register bus, one 20 MHz clock that is the shift clock
// Notes:   register offsets are byte addresses of aligned words
package pcs_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ       = 20_000_000;
    localparam int SHIFTS_PER_INSTR  = 2;  // shift clock runs at twice the instruction rate
    localparam int INSTR_FREQ_HZ     = CLK_FREQ_HZ / SHIFTS_PER_INSTR;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFS_POLY_LOW    = 8'h08;
    localparam logic [7:0] OFS_POLY_HIGH   = 8'h0C;
    localparam logic [7:0] OFS_DATA_LOW    = 8'h10;
    localparam logic [7:0] OFS_DATA_HIGH   = 8'h14;
    localparam logic [7:0] OFS_RESULT_LOW  = 8'h18;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h1C;
    localparam logic [7:0] OFS_IRQ_FLAG    = 8'h20;
    localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h24;

    // control one fields (reset value reads 16'h0040: only the empty flag)
    localparam int CON1_ENABLE_BIT  = 15;
    localparam int CON1_SIDL_BIT    = 13;
    localparam int CON1_COUNT_LSB   = 8;
    localparam int CON1_FULL_BIT    = 7;
    localparam int CON1_EMPTY_BIT   = 6;
    localparam int CON1_ISEL_BIT    = 5;
    localparam int CON1_GO_BIT      = 4;
    localparam int CON1_DIR_BIT     = 3;
    localparam logic [15:0] CON1_RESET = 16'h0040;

    // control two fields
    localparam int CON2_WIDTH_LSB   = 8;
    localparam int CON2_POLY_LENGTH_LSB    = 0;

    // interrupt flag and enable layout
    localparam int IRQ_CRC_BIT      = 3;

    // ------------------------------------------------------------------
    // fifo sizing by data width field
    // ------------------------------------------------------------------
    localparam logic [4:0] WIDTH_MAX_BYTE = 5'h07;
    localparam logic [4:0] WIDTH_MAX_HALF = 5'h0F;
    localparam logic [4:0] CAP_BYTE       = 5'h10;
    localparam logic [4:0] CAP_HALF       = 5'h08;
    localparam logic [4:0] CAP_WORD       = 5'h04;
    localparam int         FIFO_SLOTS     = 16;
    localparam int         HALF_W         = 16;

    // ------------------------------------------------------------------
    // ahb-lite
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
    localparam logic       HRESP_OKAY     = 1'h0;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } pcs_ahb_in_type;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } pcs_ahb_out_type;

    // whole state of the sequencer
    typedef struct packed {
        logic                          enable;
        logic                          stop_in_idle;
        logic                          irq_source_select;
        logic                          calc_go;
        logic                          shift_direction;
        logic [4:0]                    data_width_field;
        logic [4:0]                    poly_length;
        logic [31:0]                   poly;
        logic [31:0]                   crc;
        logic [15:0]                   hold_low;
        logic [FIFO_SLOTS-1:0][31:0]   fifo;
        logic [3:0]                    wptr;
        logic [3:0]                    rptr;
        logic [4:0]                    fifo_word_count;
        logic [31:0]                   shift_word;
        logic                          shift_valid;
        logic [4:0]                    bit_count;
        logic [7:0]                    irq_flag;
        logic [7:0]                    irq_enable;
        logic                          irq;
        logic [7:0]                    bus_addr;
        logic                          bus_wr;
        logic                          bus_rd;
        logic [31:0]                   rdata;
        logic                          ready;
    } pcs_state_type;

endpackage : pcs_pkg

// ===== src/pcs_shifter.sv
// Purpose: one step of the crc division, one message bit per call
// Assumes: polynomial length field holds the number of bits minus one
// Notes:   pure combinational; the caller owns the remainder register
`timescale 1ns/1ps
`default_nettype none
module pcs_shifter
    import pcs_pkg::*;
(
    input  wire logic [31:0] crc_in,
    input  wire logic [31:0] poly_in,
    input  wire logic [4:0]  poly_length_in,
    input  wire logic        data_bit_in,
    output logic      [31:0] crc_out
);

    // ------------------------------------------------------------------
    // feedback
    // ------------------------------------------------------------------
    // top bit of the remainder, chosen by the programmed length
    logic feedback;

    assign feedback = data_bit_in ^ crc_in[poly_length_in];

    // ------------------------------------------------------------------
    // per-bit taps
    // ------------------------------------------------------------------
    // bits above the length are held at zero so a shorter crc reads clean
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_tap
            if (i == 0) begin : g_low
                assign crc_out[i] = feedback & poly_in[i];
            end else begin : g_up
                assign crc_out[i] = (5'(i) <= poly_length_in)
                                  ? (crc_in[i-1] ^ (feedback & poly_in[i]))
                                  : 1'b0;
            end
        end
    endgenerate

endmodule : pcs_shifter
`default_nettype wire

// ===== src/pcs_top.sv
// Purpose: programmable crc sequencer with data fifo, serial engine and ahb-lite registers
// Assumes: clk_sys_in is the shift clock; the instruction clock is half of it
// Notes:   sleep_in and idle_in come from the power controller on the same clock
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcs_top
    import pcs_pkg::*;
(
    input  wire logic            clk_sys_in,
    input  wire logic            rst_n_in,
    input  wire pcs_ahb_in_type  ahb_in,
    input  wire logic            sleep_in,
    input  wire logic            idle_in,
    output pcs_ahb_out_type      ahb_out,
    output logic                 irq_out
);

    // ------------------------------------------------------------------
    // state and reset value
    // ------------------------------------------------------------------
    localparam pcs_state_type STATE_RESET = '{ready: 1'b1, default: '0};

    pcs_state_type state_reg;
    pcs_state_type state_next;

    // ------------------------------------------------------------------
    // engine datapath
    // ------------------------------------------------------------------
    logic [4:0]  bit_index;
    logic [31:0] crc_step;

    // msb first walks down from the top bit of the data width
    assign bit_index = state_reg.shift_direction
                     ? state_reg.bit_count
                     : 5'(state_reg.data_width_field - state_reg.bit_count);

    pcs_shifter u_shifter (
        .crc_in         (state_reg.crc),
        .poly_in        (state_reg.poly),
        .poly_length_in (state_reg.poly_length),
        .data_bit_in    (state_reg.shift_word[bit_index]),
        .crc_out        (crc_step)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // fifo depth follows the data width field
    function automatic logic [4:0] fifo_cap(input logic [4:0] width_field);
        if (width_field <= WIDTH_MAX_BYTE) begin
            fifo_cap = CAP_BYTE;
        end else if (width_field <= WIDTH_MAX_HALF) begin
            fifo_cap = CAP_HALF;
        end else begin
            fifo_cap = CAP_WORD;
        end
    endfunction : fifo_cap

    // register read view; data registers read as zero
    function automatic logic [31:0] read_view(input pcs_state_type s, input logic [7:0] a);
        logic [15:0] con1;
        con1                                = '0;
        con1[CON1_ENABLE_BIT]               = s.enable;
        con1[CON1_SIDL_BIT]                 = s.stop_in_idle;
        con1[CON1_COUNT_LSB +: 5]           = s.fifo_word_count;
        con1[CON1_FULL_BIT]                 = s.fifo_word_count >= fifo_cap(s.data_width_field);
        con1[CON1_EMPTY_BIT]                = s.fifo_word_count == '0;
        con1[CON1_ISEL_BIT]                 = s.irq_source_select;
        con1[CON1_GO_BIT]                   = s.calc_go;
        con1[CON1_DIR_BIT]                  = s.shift_direction;
        unique case (a)
            OFS_CONTROL_ONE: read_view = {16'h0000, con1};
            OFS_CONTROL_TWO: read_view = {19'h0, s.data_width_field, 3'h0, s.poly_length};
            OFS_POLY_LOW:    read_view = {16'h0000, s.poly[15:0]};
            OFS_POLY_HIGH:   read_view = {16'h0000, s.poly[31:16]};
            OFS_RESULT_LOW:  read_view = {16'h0000, s.crc[15:0]};
            OFS_RESULT_HIGH: read_view = {16'h0000, s.crc[31:16]};
            OFS_IRQ_FLAG:    read_view = {24'h00_0000, s.irq_flag};
            OFS_IRQ_ENABLE:  read_view = {24'h00_0000, s.irq_enable};
            default:         read_view = 32'h0000_0000;
        endcase
    endfunction : read_view

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic        take;
    logic        freeze;
    logic        push;
    logic [31:0] push_word;
    logic        pop;
    logic        word_done;
    logic        calc_done;
    logic        irq_event;
    logic [15:0] wdata;
    logic [4:0]  cap;

    always_comb begin
        state_next = state_reg;
        wdata      = ahb_in.hwdata[15:0];
        push       = 1'b0;
        push_word  = '0;
        pop        = 1'b0;
        word_done  = 1'b0;
        calc_done  = 1'b0;
        irq_event  = 1'b0;
        cap        = fifo_cap(state_reg.data_width_field);

        // sleep, or idle with stop-in-idle set, freezes the engine; idle alone does not
        freeze = sleep_in | (idle_in & state_reg.stop_in_idle);

        // address phase: reads get one wait state so a preceding write is seen
        take                = ahb_in.hsel & ahb_in.hready & (ahb_in.htrans == HTRANS_NONSEQ);
        state_next.bus_wr   = take & ahb_in.hwrite;
        state_next.bus_rd   = take & ~ahb_in.hwrite;
        state_next.bus_addr = take ? ahb_in.haddr[7:0] : state_reg.bus_addr;
        state_next.ready    = ~(take & ~ahb_in.hwrite);
        if (state_reg.bus_rd) begin
            state_next.rdata = read_view(state_reg, state_reg.bus_addr);
        end

        // data phase of a write
        if (state_reg.bus_wr) begin
            unique case (state_reg.bus_addr)
                OFS_CONTROL_ONE: begin
                    state_next.enable            = wdata[CON1_ENABLE_BIT];
                    state_next.stop_in_idle      = wdata[CON1_SIDL_BIT];
                    state_next.irq_source_select = wdata[CON1_ISEL_BIT];
                    state_next.shift_direction   = wdata[CON1_DIR_BIT];
                    // go only sets on an enabled module; clearing it raises nothing
                    state_next.calc_go = wdata[CON1_GO_BIT]
                                       & (state_reg.enable | wdata[CON1_ENABLE_BIT]);
                end
                OFS_CONTROL_TWO: begin
                    state_next.data_width_field = wdata[CON2_WIDTH_LSB +: 5];
                    state_next.poly_length      = wdata[CON2_POLY_LENGTH_LSB +: 5];
                end
                OFS_POLY_LOW:  state_next.poly[15:0]  = wdata;
                OFS_POLY_HIGH: state_next.poly[31:16] = wdata;
                OFS_DATA_LOW: begin
                    // wide words wait for their upper half before entering the fifo
                    if (state_reg.data_width_field <= WIDTH_MAX_BYTE) begin
                        push      = 1'b1;
                        push_word = {24'h00_0000, wdata[7:0]};
                    end else if (state_reg.data_width_field <= WIDTH_MAX_HALF) begin
                        push      = 1'b1;
                        push_word = {16'h0000, wdata};
                    end else begin
                        state_next.hold_low = wdata;
                    end
                end
                OFS_DATA_HIGH: begin
                    if (state_reg.data_width_field > WIDTH_MAX_HALF) begin
                        push      = 1'b1;
                        push_word = {wdata, state_reg.hold_low};
                    end
                end
                // remainder is only writable while idle, so a run is never corrupted
                OFS_RESULT_LOW: begin
                    if (!state_reg.calc_go) begin
                        state_next.crc[15:0] = wdata;
                    end
                end
                OFS_RESULT_HIGH: begin
                    if (!state_reg.calc_go) begin
                        state_next.crc[31:16] = wdata;
                    end
                end
                OFS_IRQ_FLAG:   state_next.irq_flag   = state_reg.irq_flag & ~wdata[7:0];
                OFS_IRQ_ENABLE: state_next.irq_enable = wdata[7:0];
                default: ;
            endcase
        end

        // writes beyond capacity or to a disabled module are dropped
        push = push & state_reg.enable & (state_reg.fifo_word_count < cap);

        // serial engine: one bit per clock while running and not frozen
        if (state_reg.enable && state_reg.calc_go && !freeze) begin
            if (state_reg.shift_valid) begin
                state_next.crc       = crc_step;
                state_next.bit_count = 5'(state_reg.bit_count + 5'h01);
                word_done = state_reg.bit_count == state_reg.data_width_field;
            end
            if (!state_reg.shift_valid || word_done) begin
                if (state_reg.fifo_word_count != '0) begin
                    pop = 1'b1;
                end else if (!push) begin
                    calc_done = 1'b1;
                end
            end
        end

        // buffer reload overlaps the last bit so shifting never stalls while the fifo already holds the next word
        if (pop) begin
            state_next.shift_word  = state_reg.fifo[state_reg.rptr];
            state_next.shift_valid = 1'b1;
            state_next.bit_count   = '0;
            state_next.rptr        = 4'(state_reg.rptr + 4'h1);
        end else if (word_done) begin
            state_next.shift_valid = 1'b0;
        end
        if (push) begin
            state_next.fifo[state_reg.wptr] = push_word;
            state_next.wptr                 = 4'(state_reg.wptr + 4'h1);
        end
        state_next.fifo_word_count = 5'(state_reg.fifo_word_count + 5'(push) - 5'(pop));

        // completion clears go by itself
        if (calc_done) begin
            state_next.calc_go = 1'b0;
        end

        // interrupt source: completion or count falling from one to zero
        irq_event = state_reg.irq_source_select
                  ? (pop && !push && state_reg.fifo_word_count == 5'h01)
                  : calc_done;

        // disable flushes the fifo and drops any run in progress
        if (!state_next.enable) begin
            state_next.fifo_word_count = '0;
            state_next.wptr            = '0;
            state_next.rptr            = '0;
            state_next.shift_valid     = 1'b0;
            state_next.calc_go         = 1'b0;
        end

        // sticky flag: a new event wins over a write-one clear
        if (irq_event) begin
            state_next.irq_flag[IRQ_CRC_BIT] = 1'b1;
        end

        // pending events keep reaching the output even while frozen
        state_next.irq = |(state_next.irq_flag & state_next.irq_enable);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs from the state register; hresp is tied to okay
    // ------------------------------------------------------------------
    assign ahb_out.hrdata    = state_reg.rdata;
    assign ahb_out.hreadyout = state_reg.ready;
    assign ahb_out.hresp     = HRESP_OKAY;
    assign irq_out           = state_reg.irq;

endmodule : pcs_top
`default_nettype wire

// ===== verif/pcs_asserts.sv
// Purpose: bus and interrupt checks for the crc sequencer ports
// Assumes: bus hready is looped back from hreadyout
// Notes:   helper flops remember the last written enable and mask bits
`timescale 1ns/1ps
`default_nettype none
module pcs_asserts
    import pcs_pkg::*;
(
    input  wire logic            clk_sys_in,
    input  wire logic            rst_n_in,
    input  wire pcs_ahb_in_type  ahb_in,
    input  wire logic            sleep_in,
    input  wire logic            idle_in,
    input  wire pcs_ahb_out_type ahb_out,
    input  wire logic            irq_out
);
    logic       ph_reg;
    logic       wr_reg;
    logic       en3_reg;
    logic       en15_reg;
    logic [7:0] adr_reg;
    logic       take;
    logic       done;

    // ------------------------------------------------------------------
    // transfer tracking
    // ------------------------------------------------------------------
    assign take = ahb_in.hsel & ahb_in.hready & (ahb_in.htrans == HTRANS_NONSEQ);
    assign done = ph_reg & ahb_out.hreadyout;

    // a transfer ends at the first edge that sees hreadyout high
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph_reg   <= 1'b0;
            wr_reg   <= 1'b0;
            adr_reg  <= 8'h00;
            en3_reg  <= 1'b0;
            en15_reg <= 1'b0;
        end else begin
            if (take | done)
                ph_reg <= take;
            if (take) begin
                wr_reg  <= ahb_in.hwrite;
                adr_reg <= ahb_in.haddr[7:0];
            end
            if (done & wr_reg & (adr_reg == OFS_IRQ_ENABLE))
                en3_reg <= ahb_in.hwdata[IRQ_CRC_BIT];
            if (done & wr_reg & (adr_reg == OFS_CONTROL_ONE))
                en15_reg <= ahb_in.hwdata[CON1_ENABLE_BIT];
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_rd_wait;
        !ahb_out.hreadyout ##1 ahb_out.hreadyout;
    endsequence

    rd_wait_a: assert property (take & !ahb_in.hwrite |=> s_rd_wait)
        else $error("read wait state wrong");
    wr_fast_a: assert property (take & ahb_in.hwrite |=> ahb_out.hreadyout)
        else $error("write was stalled");
    one_wait_a: assert property (!ahb_out.hreadyout |=> ahb_out.hreadyout)
        else $error("wait state too long");
    wait_cause_a: assert property ($fell(ahb_out.hreadyout) |-> $past(take & !ahb_in.hwrite))
        else $error("wait state without read");
    resp_ok_a: assert property (ahb_out.hresp == HRESP_OKAY)
        else $error("response not okay");
    // mask flop and irq_out both update at the write's data edge, so compare same-cycle
    irq_mask_a: assert property (irq_out |-> en3_reg)
        else $error("interrupt while masked");
    rd_zero_a: assert property (done & !wr_reg & (adr_reg >= 8'h28) |-> ahb_out.hrdata == '0)
        else $error("unmapped read not zero");
    off_empty_a: assert property (done & !wr_reg & (adr_reg == OFS_CONTROL_ONE) & !en15_reg
        |-> ahb_out.hrdata[12:6] == 7'h01 && !ahb_out.hrdata[CON1_GO_BIT])
        else $error("disabled module not empty");
endmodule : pcs_asserts

bind pcs_top pcs_asserts u_chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ahb_in(ahb_in), .sleep_in(sleep_in), .idle_in(idle_in), .ahb_out(ahb_out),
    .irq_out(irq_out));
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: directed bench for the crc sequencer over ahb-lite
// Assumes: one slave, so bus hready is the slave hreadyout
// Notes:   expected remainders come from a serial model kept here
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pcs_pkg::*;
;
    logic            clk_sys_in, rst_n_in, sleep_in, idle_in, irq_out, h_sel, h_wr;
    logic [1:0]      h_trans;
    logic [7:0]      h_addr;
    logic [31:0]     h_wdata, q, e;
    logic [4:0]      wf [3] = '{5'h07, 5'h0F, 5'h1F};
    logic [4:0]      cp [3] = '{5'h10, 5'h08, 5'h04};
    pcs_ahb_in_type  ai;
    pcs_ahb_out_type ao;
    int              n_fail, n_compared, k;

    assign ai = {h_sel, 24'h00_0000, h_addr, h_trans, h_wr, 3'h2, ao.hreadyout, h_wdata};
    pcs_top DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ahb_in(ai),
        .sleep_in(sleep_in), .idle_in(idle_in), .ahb_out(ao), .irq_out(irq_out));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait on a bus edge with hreadyout high; a hang ends the run
    task automatic edge_ready;
        k = 0;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (ao.hreadyout !== 1'b1 && k < 20);
        if (ao.hreadyout !== 1'b1) begin
            n_fail++;
            close_out();
        end
    endtask : edge_ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        h_sel   <= 1'b1;
        h_addr  <= a;
        h_wr    <= w;
        h_trans <= HTRANS_NONSEQ;
        edge_ready();
        h_trans <= 2'h0;
        h_wdata <= d;
        edge_ready();
        q = ao.hrdata;
    endtask : bus
    // irq_out is registered, so let two edges pass after the write
    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk_sys_in);
        chk({31'h0, irq_out}, {31'h0, v});
    endtask : irq_is
    task automatic wait_irq;
        k = 0;
        while (irq_out !== 1'b1 && k < 3000) begin
            @(posedge clk_sys_in);
            k++;
        end
        if (irq_out !== 1'b1) begin
            n_fail++;
            close_out();
        end
    endtask : wait_irq
    // reference division, one message bit per step
    function automatic logic [31:0] crc_m(input logic [31:0] c, input logic [31:0] p,
        input logic [31:0] d, input int n, input int w, input int lsb);
        logic fb;
        for (int i = 0; i < w; i++) begin
            fb = d[lsb ? i : w - 1 - i] ^ c[n];
            c = (c << 1) ^ (fb ? p : 32'h0);
        end
        return c & ((32'h2 << n) - 32'h1);
    endfunction : crc_m

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        {rst_n_in, sleep_in, idle_in, h_sel, h_wr, h_trans, h_addr, h_wdata} = '0;
        n_fail = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        chk(q, 32'h0000_0040);
        bus(1'b1, 8'h40, 32'h0000_FFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        // fill each width until refused, then disable to empty
        for (int j = 0; j < 3; j++) begin
            bus(1'b1, OFS_CONTROL_ONE, 32'h0000_8000);
            bus(1'b1, OFS_CONTROL_TWO, {19'h0, wf[j], 8'h00});
            for (int i = 0; i <= cp[j]; i++) begin
                bus(1'b1, OFS_DATA_LOW, 32'h0000_0055);
                if (wf[j] == 5'h1F)
                    bus(1'b1, OFS_DATA_HIGH, 32'h0000_00AA);
            end
            bus(1'b0, OFS_CONTROL_ONE, 32'h0);
            chk(q, {16'h0, 3'h4, cp[j], 8'h80});
            bus(1'b1, OFS_CONTROL_ONE, 32'h0);
            bus(1'b0, OFS_CONTROL_ONE, 32'h0);
            chk(q, 32'h0000_0040);
        end
        // byte data, msb first, done interrupt, idle without stop
        bus(1'b1, OFS_CONTROL_ONE, 32'h0000_8000);
        bus(1'b1, OFS_CONTROL_TWO, 32'h0000_070F);
        bus(1'b1, OFS_POLY_LOW, 32'h0000_1021);
        bus(1'b1, OFS_POLY_HIGH, 32'h0);
        e = 32'h0;
        for (int i = 1; i < 8; i++) begin
            bus(1'b1, OFS_DATA_LOW, 32'(i));
            e = crc_m(e, 32'h0000_1021, 32'(i), 15, 8, 0);
        end
        bus(1'b1, OFS_RESULT_LOW, 32'h0);
        bus(1'b1, OFS_RESULT_HIGH, 32'h0);
        bus(1'b1, OFS_IRQ_FLAG, 32'h0000_0008);
        bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0008);
        idle_in <= 1'b1;
        bus(1'b1, OFS_CONTROL_ONE, 32'h0000_8010);
        wait_irq();
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        chk(q, 32'h0000_8040);
        bus(1'b0, OFS_RESULT_LOW, 32'h0);
        chk(q, {16'h0, e[15:0]});
        idle_in <= 1'b0;
        bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
        irq_is(1'b0);
        bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0008);
        irq_is(1'b1);
        bus(1'b1, OFS_IRQ_FLAG, 32'h0000_0008);
        irq_is(1'b0);
        // word data, lsb first, count interrupt, idle stop and sleep
        bus(1'b1, OFS_CONTROL_ONE, 32'h0000_A028);
        bus(1'b1, OFS_CONTROL_TWO, 32'h0000_1F1F);
        bus(1'b1, OFS_POLY_LOW, 32'h0000_1DB7);
        bus(1'b1, OFS_POLY_HIGH, 32'h0000_04C1);
        bus(1'b1, OFS_DATA_LOW, 32'h0000_5678);
        bus(1'b1, OFS_DATA_HIGH, 32'h0000_1234);
        bus(1'b1, OFS_RESULT_LOW, 32'h0);
        bus(1'b1, OFS_RESULT_HIGH, 32'h0);
        idle_in <= 1'b1;
        bus(1'b1, OFS_CONTROL_ONE, 32'h0000_A038);
        repeat (40) @(posedge clk_sys_in);
        irq_is(1'b0);
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        chk(q, 32'h0000_A138);
        idle_in <= 1'b0;
        wait_irq();
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        chk(q, 32'h0000_A078);
        sleep_in <= 1'b1;
        repeat (60) @(posedge clk_sys_in);
        bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        chk(q, 32'h0000_A078);
        sleep_in <= 1'b0;
        for (int i = 0; i < 50 && q[CON1_GO_BIT] !== 1'b0; i++)
            bus(1'b0, OFS_CONTROL_ONE, 32'h0);
        chk(q, 32'h0000_A068);
        bus(1'b0, OFS_RESULT_HIGH, 32'h0);
        e = q;
        bus(1'b0, OFS_RESULT_LOW, 32'h0);
        chk({e[15:0], q[15:0]}, crc_m(32'h0, 32'h04C1_1DB7, 32'h1234_5678, 31, 32, 1));
        // software stop must stay silent
        bus(1'b1, OFS_IRQ_FLAG, 32'h0000_0008);
        bus(1'b1, OFS_CONTROL_ONE, 32'h0000_8000);
        bus(1'b1, OFS_DATA_LOW, 32'h0000_0001);
        bus(1'b1, OFS_DATA_HIGH, 32'h0000_0002);
        bus(1'b1, OFS_CONTROL_ONE, 32'h0000_8010);
        bus(1'b1, OFS_CONTROL_ONE, 32'h0000_8000);
        repeat (60) @(posedge clk_sys_in);
        irq_is(1'b0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
